// ---- hw/sc_seq_pkg.sv ----
// Purpose: shared constants and carriers for the smart card session sequencer
// Assumes: 10 MHz system clock, classic Wishbone with 32-bit data
// Notes: times are kept in their own unit; cycle counts derive from CLK_KHZ
package sc_seq_pkg;
  // system clock rate in kHz (100 ns period)
  localparam int CLK_KHZ = 10000;
  // internal power-on hold, in microseconds
  localparam int POR_TIME_US = 8000;
  localparam int POR_CYCLES = POR_TIME_US * CLK_KHZ / 1000;
  // card insertion debounce, in microseconds
  localparam int DEBOUNCE_TIME_US = 8000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * CLK_KHZ / 1000;
  // card reset low to card clock low, in nanoseconds (least time, rounds up)
  localparam int DEACT_CLK_DELAY_NS = 12000;
  localparam int DEACT_CLK_CYCLES = (DEACT_CLK_DELAY_NS * CLK_KHZ + 999999) / 1000000;
  // spacing between activation and deactivation steps, in nanoseconds
  localparam int STEP_TIME_NS = 10000;
  localparam int STEP_CYCLES = (STEP_TIME_NS * CLK_KHZ + 999999) / 1000000;
  // width of the shared interval counter
  localparam int TIMER_W = 17;

  // register byte addresses
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  // control field positions and reset value
  localparam int CTRL_CLK_START_BIT = 0;
  localparam logic CTRL_CLK_START_RST = 1'b1;
  // status field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_PRESENT_BIT = 4;
  localparam int STAT_FAULT_BIT = 5;
  localparam int STAT_LOCKOUT_BIT = 6;
  localparam int STAT_CLK_RUN_BIT = 7;
  localparam int STAT_WAIT_RST_BIT = 8;

  // channel index: data, aux a, aux b
  localparam int CHANNELS = 3;

  // session sequencer, gray codes along the activation path
  typedef enum logic [3:0] {
    ST_POR = 4'h0,
    ST_STANDBY = 4'h1,
    ST_RAMP = 4'h3,
    ST_CHAN = 4'h2,
    ST_CLK = 4'h6,
    ST_RST = 4'h7,
    ST_ACTIVE = 4'h5,
    ST_DEACT = 4'h4,
    ST_DOWN = 4'hc
  } seq_state_t;

  // per-channel direction
  typedef enum logic [1:0] {
    CH_IDLE = 2'h0,
    CH_HOST = 2'h1,
    CH_CARD = 2'h3
  } chan_state_t;

  // wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  // wishbone answer from this slave
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;
endpackage : sc_seq_pkg

// ---- hw/sc_session_seq.sv ----
// Purpose: control logic of one smart card interface: lockout, power-on hold,
//   presence flag, activation and deactivation order, card clock divider and
//   three direction-sensing data/aux channels, with a Wishbone register port
// Assumes: every pin input is asynchronous and passes two flip-flops first
// Notes: channel arrays index 0 = data line, 1 = aux line a, 2 = aux line b
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
module sc_session_seq #(
  parameter int POR_CYCLES = sc_seq_pkg::POR_CYCLES,
  parameter int DEBOUNCE_CYCLES = sc_seq_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sc_seq_pkg::wb_req_t wb_req_i,
  output sc_seq_pkg::wb_rsp_t wb_rsp_o,
  input wire logic supply_ok_i,
  input wire logic card_detect_in_i,
  input wire logic card_supply_ok_i,
  input wire logic card_fault_i,
  input wire logic session_request_n_i,
  input wire logic card_reset_request_i,
  input wire logic clock_ratio_select_a_i,
  input wire logic clock_ratio_select_b_i,
  input wire logic source_clock_in_i,
  input wire logic [2:0] host_line_i,
  output logic [2:0] host_line_o,
  output logic [2:0] host_line_oe_o,
  input wire logic [2:0] card_line_i,
  output logic [2:0] card_line_o,
  output logic [2:0] card_line_oe_o,
  output logic card_supply_en_o,
  output logic card_clock_out_o,
  output logic card_reset_out_o,
  output logic event_flag_n_o
);
  // two-flop synchronisers for the single pins; stage one feeds stage two only
  localparam int NPIN = 9;
  logic [NPIN-1:0] pin_meta_reg;
  logic [NPIN-1:0] pin_sync_reg;
  wire [NPIN-1:0] pin_raw = {source_clock_in_i, clock_ratio_select_b_i,
    clock_ratio_select_a_i, card_reset_request_i, session_request_n_i,
    card_fault_i, card_supply_ok_i, card_detect_in_i, supply_ok_i};

  // named views of the synchronised pins
  wire supply_ok_s = pin_sync_reg[0];
  wire detect_s = pin_sync_reg[1];
  wire card_supply_ok_s = pin_sync_reg[2];
  wire fault_s = pin_sync_reg[3];
  wire session_req_n_s = pin_sync_reg[4];
  wire reset_req_s = pin_sync_reg[5];
  wire [1:0] ratio_s = {pin_sync_reg[6], pin_sync_reg[7]};
  wire src_s = pin_sync_reg[8];

  // pin synchronisers run through reset so the first sample is fresh
  always_ff @(posedge clk_i) begin
    pin_meta_reg <= pin_raw;
    pin_sync_reg <= pin_meta_reg;
  end

  // state and timers
  sc_seq_pkg::seq_state_t state_reg;
  sc_seq_pkg::seq_state_t state_next;
  logic [sc_seq_pkg::TIMER_W-1:0] timer_reg; // shared step and hold counter
  logic [sc_seq_pkg::TIMER_W-1:0] deb_reg; // insertion debounce counter
  logic present_reg; // debounced card presence
  logic fault_reg; // session fault seen, cleared back in idle standby
  logic clk_start_en_reg; // software: allow host-held clock start
  logic hold_clk_reg; // clock start waits for reset request to fall

  // lockout and deactivation causes
  wire lockout = ~supply_ok_s;
  wire in_session = (state_reg == sc_seq_pkg::ST_RAMP) || (state_reg == sc_seq_pkg::ST_CHAN) ||
    (state_reg == sc_seq_pkg::ST_CLK) || (state_reg == sc_seq_pkg::ST_RST) ||
    (state_reg == sc_seq_pkg::ST_ACTIVE);
  wire session_fault = in_session && (fault_s || lockout || !detect_s);
  wire abort = in_session && (session_req_n_s || session_fault);
  wire timer_done = (timer_reg == '0);
  wire step_load = (state_reg != state_next);
  wire session_open = present_reg && !session_req_n_s && !lockout && !fault_reg;

  // next sequencer state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sc_seq_pkg::ST_POR: begin
        // wait out the power-on hold with the supply good throughout
        if (supply_ok_s && timer_done)
          state_next = sc_seq_pkg::ST_STANDBY;
      end
      sc_seq_pkg::ST_STANDBY: begin
        if (lockout)
          state_next = sc_seq_pkg::ST_POR;
        else if (session_open)
          state_next = sc_seq_pkg::ST_RAMP;
      end
      sc_seq_pkg::ST_RAMP: begin
        if (abort)
          state_next = sc_seq_pkg::ST_DEACT;
        else if (card_supply_ok_s)
          state_next = sc_seq_pkg::ST_CHAN;
      end
      sc_seq_pkg::ST_CHAN: begin
        if (abort)
          state_next = sc_seq_pkg::ST_DEACT;
        else if (timer_done && !(hold_clk_reg && reset_req_s))
          state_next = sc_seq_pkg::ST_CLK;
      end
      sc_seq_pkg::ST_CLK: begin
        if (abort)
          state_next = sc_seq_pkg::ST_DEACT;
        else if (timer_done)
          state_next = sc_seq_pkg::ST_RST;
      end
      sc_seq_pkg::ST_RST: begin
        if (abort)
          state_next = sc_seq_pkg::ST_DEACT;
        else if (timer_done)
          state_next = sc_seq_pkg::ST_ACTIVE;
      end
      sc_seq_pkg::ST_ACTIVE: begin
        if (abort)
          state_next = sc_seq_pkg::ST_DEACT;
      end
      sc_seq_pkg::ST_DEACT: begin
        // card reset already low; clock drops after the delay
        if (timer_done)
          state_next = sc_seq_pkg::ST_DOWN;
      end
      sc_seq_pkg::ST_DOWN: begin
        // lines low, then the supply goes off on leaving
        if (timer_done)
          state_next = sc_seq_pkg::ST_STANDBY;
      end
      default: state_next = sc_seq_pkg::ST_POR;
    endcase
  end

  // reload value for the shared timer on each state change
  logic [sc_seq_pkg::TIMER_W-1:0] timer_load;
  always_comb begin
    timer_load = sc_seq_pkg::TIMER_W'(sc_seq_pkg::STEP_CYCLES - 1);
    if (state_next == sc_seq_pkg::ST_POR)
      timer_load = sc_seq_pkg::TIMER_W'(POR_CYCLES - 1);
    else if (state_next == sc_seq_pkg::ST_DEACT)
      timer_load = sc_seq_pkg::TIMER_W'(sc_seq_pkg::DEACT_CLK_CYCLES - 1);
  end

  // sequencer and timer; a lockout in power-on restarts the full hold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= sc_seq_pkg::ST_POR;
      timer_reg <= sc_seq_pkg::TIMER_W'(POR_CYCLES - 1);
    end else begin
      state_reg <= state_next;
      if (step_load || (state_reg == sc_seq_pkg::ST_POR && lockout))
        timer_reg <= timer_load;
      else if (!timer_done)
        timer_reg <= timer_reg - 1'b1;
    end
  end

  // clock-start hold is caught when activation begins
  always_ff @(posedge clk_i) begin
    if (rst_i)
      hold_clk_reg <= 1'b0;
    else if (state_reg == sc_seq_pkg::ST_STANDBY && session_open)
      hold_clk_reg <= clk_start_en_reg && reset_req_s;
  end

  // debounce: insertion counts up, removal clears at once
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg == sc_seq_pkg::ST_POR || !detect_s) begin
      deb_reg <= '0;
      present_reg <= 1'b0;
    end else if (deb_reg == sc_seq_pkg::TIMER_W'(DEBOUNCE_CYCLES - 1)) begin
      present_reg <= 1'b1;
    end else begin
      deb_reg <= deb_reg + 1'b1;
    end
  end

  // fault latch: a new fault wins over the clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i)
      fault_reg <= 1'b0;
    else if (session_fault)
      fault_reg <= 1'b1;
    else if (state_reg == sc_seq_pkg::ST_STANDBY && session_req_n_s)
      fault_reg <= 1'b0;
  end

  // event flag: high only for a settled, present card with no fault
  wire flag_next = present_reg && !lockout && !fault_reg && !session_fault &&
    (state_reg != sc_seq_pkg::ST_POR);
  always_ff @(posedge clk_i) begin
    if (rst_i)
      event_flag_n_o <= 1'b0;
    else
      event_flag_n_o <= flag_next;
  end

  // card supply, reset and clock gating per state
  logic [3:0] live_reg; // [2:0] lines_en history, [3] clock on: teardown keeps only what ran
  wire supply_next = in_session || state_reg == sc_seq_pkg::ST_DEACT ||
    state_reg == sc_seq_pkg::ST_DOWN;
  wire clk_en = in_session && (state_reg != sc_seq_pkg::ST_RAMP) &&
    (state_reg != sc_seq_pkg::ST_CHAN);
  wire clk_en_full = clk_en || (state_reg == sc_seq_pkg::ST_DEACT && live_reg[3]);
  wire lines_en = clk_en || (state_reg == sc_seq_pkg::ST_CHAN) ||
    (state_reg == sc_seq_pkg::ST_DEACT && live_reg[0]);
  wire rst_next = (state_reg == sc_seq_pkg::ST_ACTIVE) && !abort;

  // source clock divider: count source rising edges, toggle a final flop
  logic src_last_reg; // previous synchronised source level
  logic [1:0] div_cnt_reg;
  logic div_q_reg; // final divider flop, gives even duty
  wire src_rise = src_s && !src_last_reg;
  logic [1:0] div_top;
  always_comb begin
    unique case (ratio_s)
      2'h0: div_top = 2'h3; // divide by 8
      2'h1: div_top = 2'h1; // divide by 4
      2'h2: div_top = 2'h0; // divide by 1, bypassed below
      2'h3: div_top = 2'h0; // divide by 2
    endcase
  end
  wire div_tick = src_rise && (div_cnt_reg >= div_top);
  wire ratio_one = (ratio_s == 2'h2);
  wire card_clk_next = clk_en_full && (ratio_one ? src_s : div_q_reg);

  // divider runs free so the phase is settled before the clock is let out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_last_reg <= 1'b0;
      div_cnt_reg <= 2'h0;
      div_q_reg <= 1'b0;
    end else begin
      src_last_reg <= src_s;
      if (div_tick) begin
        div_cnt_reg <= 2'h0;
        div_q_reg <= !div_q_reg;
      end else if (src_rise) begin
        div_cnt_reg <= div_cnt_reg + 1'b1;
      end
    end
  end

  // card-side single outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      card_supply_en_o <= 1'b0;
      card_reset_out_o <= 1'b0;
      card_clock_out_o <= 1'b0;
      live_reg <= 4'h0;
    end else begin
      live_reg <= {clk_en_full, live_reg[1:0], lines_en};
      card_supply_en_o <= supply_next;
      card_reset_out_o <= rst_next;
      card_clock_out_o <= card_clk_next;
    end
  end

  // three identical direction-sensing channels
  for (genvar ch = 0; ch < sc_seq_pkg::CHANNELS; ch++) begin : g_chan
    logic [1:0] meta_reg; // {host, card} first stage
    logic [1:0] sync_reg; // {host, card} second stage
    sc_seq_pkg::chan_state_t dir_reg;
    sc_seq_pkg::chan_state_t dir_next;
    wire host_s = sync_reg[1];
    wire card_s = sync_reg[0];

    // synchronise both sides of the channel
    always_ff @(posedge clk_i) begin
      meta_reg <= {host_line_i[ch], card_line_i[ch]};
      sync_reg <= meta_reg;
    end

    // first side to fall owns the channel until both sides sit high
    always_comb begin
      dir_next = dir_reg;
      unique case (dir_reg)
        sc_seq_pkg::CH_IDLE: begin
          if (!lines_en || !live_reg[2]) // our own standby low still in the input flops
            dir_next = sc_seq_pkg::CH_IDLE;
          else if (!host_s)
            dir_next = sc_seq_pkg::CH_HOST;
          else if (!card_s)
            dir_next = sc_seq_pkg::CH_CARD;
        end
        sc_seq_pkg::CH_HOST, sc_seq_pkg::CH_CARD: begin
          if (!lines_en || (host_s && card_s))
            dir_next = sc_seq_pkg::CH_IDLE;
        end
        default: dir_next = sc_seq_pkg::CH_IDLE;
      endcase
    end

    // outputs: standby pulls the card pin low and releases the host pin
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        dir_reg <= sc_seq_pkg::CH_IDLE;
        card_line_o[ch] <= 1'b0;
        card_line_oe_o[ch] <= 1'b1;
        host_line_o[ch] <= 1'b0;
        host_line_oe_o[ch] <= 1'b0;
      end else begin
        dir_reg <= dir_next;
        card_line_oe_o[ch] <= !lines_en || dir_next == sc_seq_pkg::CH_HOST;
        card_line_o[ch] <= lines_en && host_s; // drives high briefly as active pull-up
        host_line_oe_o[ch] <= lines_en && dir_next == sc_seq_pkg::CH_CARD;
        host_line_o[ch] <= card_s;
      end
    end
  end

  // wishbone slave: one wait state, ack drops the cycle after it rises
  wire wb_hit = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  wire wr_ctrl = wb_hit && wb_req_i.we && wb_req_i.sel[0] &&
    (wb_req_i.adr == sc_seq_pkg::CTRL_ADDR);
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    if (wb_req_i.adr == sc_seq_pkg::CTRL_ADDR) begin
      rd_data[sc_seq_pkg::CTRL_CLK_START_BIT] = clk_start_en_reg;
    end else if (wb_req_i.adr == sc_seq_pkg::STATUS_ADDR) begin
      rd_data[sc_seq_pkg::STAT_STATE_LSB +: 4] = state_reg;
      rd_data[sc_seq_pkg::STAT_PRESENT_BIT] = present_reg;
      rd_data[sc_seq_pkg::STAT_FAULT_BIT] = fault_reg;
      rd_data[sc_seq_pkg::STAT_LOCKOUT_BIT] = lockout;
      rd_data[sc_seq_pkg::STAT_CLK_RUN_BIT] = clk_en;
      rd_data[sc_seq_pkg::STAT_WAIT_RST_BIT] = hold_clk_reg;
    end
  end

  // register write and bus answer; unmapped addresses read zero and are acked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_start_en_reg <= sc_seq_pkg::CTRL_CLK_START_RST;
      wb_rsp_o <= '0;
    end else begin
      if (wr_ctrl)
        clk_start_en_reg <= wb_req_i.dat[sc_seq_pkg::CTRL_CLK_START_BIT];
      wb_rsp_o.ack <= wb_hit;
      wb_rsp_o.dat <= wb_hit ? rd_data : 32'h0000_0000;
    end
  end
endmodule : sc_session_seq

// ---- sim/sc_card_model.sv ----
// Purpose: behavioural smart card on the far side of the sequencer
// Assumes: card pins carry pull-ups; supply settles a while after enable
// Notes: the bench decides when the card sinks a line
`timescale 1ns/100ps
module sc_card_model #(
  parameter int RAMP_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic card_supply_en_i,
  input wire logic [2:0] card_line_o_i,
  input wire logic [2:0] card_line_oe_i,
  input wire logic [2:0] card_pull_low_i,
  output logic card_supply_ok_o,
  output logic [2:0] card_line_w_o
);
  int ramp_cnt = 0; // cycles the enable has stood
  initial card_supply_ok_o = 1'b0;
  // supply ramp: ok drops at once when the enable goes away
  always @(posedge clk_i) begin
    if (!card_supply_en_i) ramp_cnt <= 0;
    else if (ramp_cnt < RAMP_CYCLES) ramp_cnt <= ramp_cnt + 1;
    card_supply_ok_o <= card_supply_en_i && ramp_cnt == RAMP_CYCLES;
  end
  // wired-and line: high unless either party sinks it
  assign card_line_w_o = ~(card_line_oe_i & ~card_line_o_i) & ~card_pull_low_i;
endmodule : sc_card_model

// ---- sim/sc_session_seq_monitor.sv ----
// Purpose: concurrent checks on the session sequencer ports
// Assumes: one clock domain, rst_i synchronous and active high
// Notes: pin effects lag about three cycles through the input flops
`timescale 1ns/100ps
module sc_session_seq_monitor #(
  parameter int POR_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sc_seq_pkg::wb_req_t wb_req_i,
  input wire sc_seq_pkg::wb_rsp_t wb_rsp_o,
  input wire logic supply_ok_i,
  input wire logic card_detect_in_i,
  input wire logic card_fault_i,
  input wire logic [2:0] card_line_o,
  input wire logic [2:0] card_line_oe_o,
  input wire logic card_supply_en_o,
  input wire logic card_clock_out_o,
  input wire logic card_reset_out_o,
  input wire logic event_flag_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int por_cnt; // cycles since reset release, saturates
  // a mid-run reset restarts the count, so the hold is checked again
  always_ff @(posedge clk_i) begin
    if (rst_i) por_cnt <= 0;
    else if (por_cnt < POR_CYCLES) por_cnt <= por_cnt + 1;
  end
  wb_ack_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack
    |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack) else $error("bus ack not a single pulse");
  por_quiet_a: assert property (
    por_cnt < POR_CYCLES |-> !card_supply_en_o && !event_flag_n_o)
    else $error("activity during power-on hold");
  lockout_down_a: assert property (
    $fell(supply_ok_i) |-> ##[1:8] (!event_flag_n_o && !card_reset_out_o))
    else $error("supply drop not handled");
  no_card_flag_a: assert property (
    !card_detect_in_i [*5] |-> !event_flag_n_o) else $error("flag high with no card");
  debounce_hold_a: assert property (
    $rose(card_detect_in_i) |-> !event_flag_n_o [*8]) else $error("flag rose too early");
  fault_flag_a: assert property (
    $rose(card_fault_i) |-> ##[1:6] !event_flag_n_o) else $error("fault left flag high");
  idle_pins_low_a: assert property (
    !card_supply_en_o |-> !card_clock_out_o && !card_reset_out_o
    && card_line_oe_o == 3'h7 && card_line_o == 3'h0) else $error("card pin live unpowered");
  clk_after_act_a: assert property (
    card_clock_out_o |-> card_supply_en_o && card_line_oe_o != 3'h7)
    else $error("card clock before channels");
  rst_last_a: assert property (
    $rose(card_reset_out_o) |-> card_supply_en_o && $past(card_line_oe_o, 100) != 3'h7)
    else $error("card reset released out of order");
  deact_order_a: assert property (
    $fell(card_reset_out_o) |-> card_supply_en_o throughout
    (##[118:125] (!card_clock_out_o && card_line_oe_o == 3'h7)))
    else $error("deactivation order broken");
endmodule : sc_session_seq_monitor

bind sc_session_seq sc_session_seq_monitor #(.POR_CYCLES(POR_CYCLES)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .supply_ok_i(supply_ok_i), .card_detect_in_i(card_detect_in_i),
  .card_fault_i(card_fault_i), .card_line_o(card_line_o), .card_line_oe_o(card_line_oe_o),
  .card_supply_en_o(card_supply_en_o), .card_clock_out_o(card_clock_out_o),
  .card_reset_out_o(card_reset_out_o), .event_flag_n_o(event_flag_n_o));

// ---- sim/sc_session_seq_test.sv ----
// Purpose: self-checking bench for the smart card session sequencer
// Assumes: short power-on and debounce counts; source clock is clk_i / 8
// Notes: each scenario task drives the pins and judges the result itself
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module sc_session_seq_test;
  localparam int POR_CYC = 20;
  localparam int DEB_CYC = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  sc_seq_pkg::wb_req_t wb_req = '0;
  sc_seq_pkg::wb_rsp_t wb_rsp;
  logic supply_ok = 1'b1; // logic supply above lockout
  logic card_in = 1'b0; // card in connector
  logic card_ok; // card supply settled, from the card model
  logic fault = 1'b0;
  logic req_n = 1'b1; // session request, active low
  logic rst_req = 1'b0; // host card reset request
  logic [1:0] ratio = 2'b11; // {a, b} ratio pins
  logic [2:0] src_div = 3'h0; // source clock is the top bit
  logic [2:0] host_rel = 3'h7; // host side: 0 sinks the line
  logic [2:0] card_low = 3'h0; // card side: 1 sinks the line
  wire logic [2:0] host_w, card_w, host_o, host_oe, card_o, card_oe;
  wire logic supply_en, card_clk, card_rst, flag_n;
  wire logic [3:0] mon = {supply_en, card_clk, card_rst, flag_n};
  int num_errors = 0;
  int n_checks = 0;
  logic [31:0] rd;
  always #50 clk_i = ~clk_i;
  // slow source clock, well inside what the input flops can follow
  always @(posedge clk_i) src_div <= src_div + 3'h1;
  // host side wire: pull-up, low when the block or the host sinks it
  assign host_w = ~(host_oe & ~host_o) & host_rel;
  sc_session_seq #(.POR_CYCLES(POR_CYC), .DEBOUNCE_CYCLES(DEB_CYC)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .supply_ok_i(supply_ok), .card_detect_in_i(card_in), .card_supply_ok_i(card_ok),
    .card_fault_i(fault), .session_request_n_i(req_n), .card_reset_request_i(rst_req),
    .clock_ratio_select_a_i(ratio[1]), .clock_ratio_select_b_i(ratio[0]),
    .source_clock_in_i(src_div[2]), .host_line_i(host_w), .host_line_o(host_o),
    .host_line_oe_o(host_oe), .card_line_i(card_w), .card_line_o(card_o),
    .card_line_oe_o(card_oe), .card_supply_en_o(supply_en), .card_clock_out_o(card_clk),
    .card_reset_out_o(card_rst), .event_flag_n_o(flag_n));
  sc_card_model #(.RAMP_CYCLES(20)) u_card (.clk_i(clk_i), .card_supply_en_i(supply_en),
    .card_line_o_i(card_o), .card_line_oe_i(card_oe), .card_pull_low_i(card_low),
    .card_supply_ok_o(card_ok), .card_line_w_o(card_w));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  // wait for one bit of mon to reach v; running out of cycles ends the run
  task automatic wait_sig(input int s, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk_i);
      if (mon[s] === v) return;
    end
    $display("wrong value wait %0d exp %0h got %0h", s, v, mon[s]);
    num_errors++;
    tally_and_finish();
  endtask : wait_sig
  // classic single cycle: hold everything until ack is sampled high
  task automatic wb_cyc(input logic we, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int i;
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_rsp.ack === 1'b1) break;
    end
    q = wb_rsp.dat;
    wb_req <= '0;
    if (i == 20) begin
      `CHK("bus ack", 1'b1, 1'b0)
      tally_and_finish();
    end
  endtask : wb_cyc
  task automatic t_reset();
    `CHK("flag", 1'b0, flag_n)
    `CHK("card oe", 3'h7, card_oe)
    `CHK("host oe", 3'h0, host_oe)
    wb_cyc(1'b0, sc_seq_pkg::CTRL_ADDR, 32'h0, rd);
    `CHK("ctrl reset", sc_seq_pkg::CTRL_CLK_START_RST, rd[0])
    wb_cyc(1'b1, sc_seq_pkg::CTRL_ADDR, 32'h0, rd);
    wb_cyc(1'b0, sc_seq_pkg::CTRL_ADDR, 32'h0, rd);
    `CHK("ctrl rw", 1'b0, rd[0])
    wb_cyc(1'b1, sc_seq_pkg::CTRL_ADDR, 32'h1, rd);
    wb_cyc(1'b0, 4'h8, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    wb_cyc(1'b0, sc_seq_pkg::STATUS_ADDR, 32'h0, rd);
    `CHK("state por", sc_seq_pkg::ST_POR, rd[3:0])
    cyc(POR_CYC + 5);
    wb_cyc(1'b0, sc_seq_pkg::STATUS_ADDR, 32'h0, rd);
    `CHK("state standby", sc_seq_pkg::ST_STANDBY, rd[3:0])
    $display("test reset done");
  endtask : t_reset
  task automatic t_present();
    req_n <= 1'b0; // no card yet, so this must be ignored
    cyc(10);
    `CHK("supply no card", 1'b0, supply_en)
    req_n <= 1'b1;
    card_in <= 1'b1;
    cyc(DEB_CYC);
    `CHK("flag early", 1'b0, flag_n)
    wait_sig(0, 1'b1, 20);
    $display("test presence done");
  endtask : t_present
  task automatic t_active();
    int n, hi;
    logic p;
    int exp_n[4] = '{4, 8, 32, 16};
    req_n <= 1'b0;
    wait_sig(3, 1'b1, 20);
    cyc(3);
    `CHK("ramp pins", 5'h07, {card_clk, card_rst, card_oe})
    wait_sig(1, 1'b1, 600);
    `CHK("lines at reset", 3'h0, card_oe)
    for (int k = 0; k < 4; k++) begin
      ratio <= k[1:0];
      cyc(40);
      n = 0;
      hi = 0;
      p = card_clk;
      repeat (256) begin
        @(posedge clk_i);
        hi += int'(card_clk === 1'b1);
        if (card_clk === 1'b1 && p === 1'b0) n++;
        p = card_clk;
      end
      `CHK("clock edges", 1'b1, n >= exp_n[k] - 1 && n <= exp_n[k] + 1)
      `CHK("clock duty", 1'b1, hi >= 120 && hi <= 136)
    end
    ratio <= 2'b11;
    host_rel <= 3'h6; // held for many cycles, far below the line rate limit
    cyc(8);
    `CHK("card data driven", 2'b10, {card_oe[0], card_o[0]})
    host_rel <= 3'h7;
    cyc(8);
    `CHK("data idle", 1'b0, card_oe[0])
    card_low <= 3'h2;
    cyc(8);
    `CHK("host aux driven", 3'h4, {host_oe[1], host_o[1], card_oe[1]})
    card_low <= 3'h0;
    cyc(8);
    $display("test activation done");
  endtask : t_active
  task automatic t_deact();
    req_n <= 1'b1;
    wait_sig(1, 1'b0, 10);
    `CHK("supply after rst low", 1'b1, supply_en)
    wait_sig(3, 1'b0, 400);
    `CHK("lines low", 4'h7, {card_clk, card_oe})
    cyc(10);
    `CHK("flag present", 1'b1, flag_n)
    $display("test deactivation done");
  endtask : t_deact
  task automatic t_held();
    rst_req <= 1'b1; // raised before the session request
    cyc(5);
    req_n <= 1'b0;
    wait_sig(3, 1'b1, 20);
    cyc(500);
    `CHK("clock held", 1'b0, card_clk)
    wb_cyc(1'b0, sc_seq_pkg::STATUS_ADDR, 32'h0, rd);
    `CHK("held bit", 1'b1, rd[sc_seq_pkg::STAT_WAIT_RST_BIT])
    rst_req <= 1'b0;
    wait_sig(2, 1'b1, 30);
    wait_sig(1, 1'b1, 200);
    $display("test held clock done");
  endtask : t_held
  task automatic t_fault();
    fault <= 1'b1;
    cyc(8);
    `CHK("fault pins", 2'b00, {flag_n, card_rst})
    wait_sig(3, 1'b0, 400);
    fault <= 1'b0;
    req_n <= 1'b1;
    wait_sig(0, 1'b1, 20);
    supply_ok <= 1'b0;
    cyc(8);
    `CHK("flag lockout", 1'b0, flag_n)
    supply_ok <= 1'b1;
    cyc(POR_CYC - 5);
    `CHK("flag por hold", 1'b0, flag_n)
    wait_sig(0, 1'b1, 60);
    req_n <= 1'b0;
    wait_sig(3, 1'b1, 20);
    card_in <= 1'b0; // card pulled out mid-session
    cyc(8);
    `CHK("flag removal", 1'b0, flag_n)
    wait_sig(3, 1'b0, 400);
    req_n <= 1'b1;
    $display("test faults done");
  endtask : t_fault
  // main sequence: reset for four cycles, then every scenario in turn
  initial begin
    cyc(4);
    rst_i <= 1'b0;
    t_reset();
    t_present();
    t_active();
    t_deact();
    t_held();
    t_fault();
    tally_and_finish();
  end
endmodule : sc_session_seq_test
